// >>> hdl/cpu_register_set.sv
// CPU register set with banks, stack pointers and flag word
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_set (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic SOFT_RESET,
    input wire logic [3:0] ADDR,
    input wire logic [19:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [19:0] RDATA,
    input wire logic [3:0] BYTE_SEL,
    output logic [7:0] DATA_REG0_UPPER_BYTE,
    output logic [7:0] DATA_REG0_LOWER_BYTE,
    output logic [7:0] DATA_REG1_UPPER_BYTE,
    output logic [7:0] DATA_REG1_LOWER_BYTE,
    output logic [31:0] DATA_PAIR_LOW_32,
    output logic [31:0] DATA_PAIR_HIGH_32,
    output logic [31:0] ADDRESS_PAIR_32,
    output logic [15:0] ACTIVE_SP,
    output logic [15:0] FLAGS,
    input wire logic COND_WE,
    input wire logic [3:0] COND_FLAGS,
    input wire logic INSN_DONE,
    output logic STEP_REQ,
    input wire logic IRQ_REQ,
    input wire logic [2:0] IRQ_LEVEL,
    input wire logic IRQ_MASKABLE,
    output logic IRQ_ACCEPT,
    input wire logic SOFT_INT,
    input wire logic [5:0] SOFT_INT_NUM,
    input wire logic PC_WE,
    input wire logic [19:0] PC_NEXT,
    output logic [19:0] INSTRUCTION_POINTER,
    output logic VECTOR_FETCH,
    input wire logic VECTOR_VALID,
    input wire logic [19:0] VECTOR_DATA,
    output logic RUNNING
);
    // Banked storage: index 0..3 data, 4..5 address, 6 frame base
    logic [15:0] bank0 [0:6];
    logic [15:0] bank1 [0:6];
    logic [19:0] vector_table_base;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] static_base;
    logic [15:0] processor_flags_word;
    logic [19:0] instruction_pointer;
    logic [15:0] next_flags;
    logic [15:0] view [0:6];
    logic soft_rst_q;
    logic bank_sel;
    logic step_pending;
    logic accept;
    cpu_regs_pkg::boot_state_t state;
    cpu_regs_pkg::boot_state_t next_state;

    // Software reset is registered, then acts as a full reset
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= SOFT_RESET; // [RULE22]
        end
    end

    // Byte write merge for the split low data registers
    function automatic logic [15:0] merge(input logic [15:0] old,
            input logic [15:0] nw, input logic [1:0] be);
        merge = old;
        if (be[0]) begin
            merge[7:0] = nw[7:0];
        end
        if (be[1]) begin
            merge[15:8] = nw[15:8];
        end
    endfunction

    assign bank_sel = processor_flags_word[cpu_regs_pkg::FLG_BANK]; // [RULE16]

    // Visible bank view; only one bank reaches the ports [RULE6]
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            view[i] = bank_sel ? bank1[i] : bank0[i];
        end
    end

    // Banked register writes; byte lanes only matter for the first two
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < 7; i++) begin
                bank0[i] <= cpu_regs_pkg::RST_WORD; // [RULE23]
                bank1[i] <= cpu_regs_pkg::RST_WORD;
            end
        end else if (soft_rst_q) begin
            for (int i = 0; i < 7; i++) begin
                bank0[i] <= cpu_regs_pkg::RST_WORD; // [RULE22]
                bank1[i] <= cpu_regs_pkg::RST_WORD;
            end
        end else if (WR && ADDR <= cpu_regs_pkg::SEL_FRAME) begin
            // [RULE1] [RULE2] [RULE4] [RULE7]
            if (bank_sel) begin
                bank1[ADDR[2:0]] <= merge(bank1[ADDR[2:0]], WDATA[15:0],
                    (ADDR <= cpu_regs_pkg::SEL_DATA1) ? BYTE_SEL[1:0]
                    : 2'h3);
            end else begin
                bank0[ADDR[2:0]] <= merge(bank0[ADDR[2:0]], WDATA[15:0],
                    (ADDR <= cpu_regs_pkg::SEL_DATA1) ? BYTE_SEL[1:0]
                    : 2'h3);
            end
        end
    end

    // Unbanked pointers and bases
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            vector_table_base <= cpu_regs_pkg::RST_ADDR; // [RULE23]
            user_stack_pointer <= cpu_regs_pkg::RST_WORD;
            interrupt_stack_pointer <= cpu_regs_pkg::RST_WORD;
            static_base <= cpu_regs_pkg::RST_WORD;
        end else if (soft_rst_q) begin
            vector_table_base <= cpu_regs_pkg::RST_ADDR; // [RULE22]
            user_stack_pointer <= cpu_regs_pkg::RST_WORD;
            interrupt_stack_pointer <= cpu_regs_pkg::RST_WORD;
            static_base <= cpu_regs_pkg::RST_WORD;
        end else if (WR) begin
            case (ADDR)
                cpu_regs_pkg::SEL_VTAB: vector_table_base <= WDATA; // [RULE9]
                cpu_regs_pkg::SEL_USP: user_stack_pointer <= WDATA[15:0];
                cpu_regs_pkg::SEL_ISP: begin
                    interrupt_stack_pointer <= WDATA[15:0];
                end
                cpu_regs_pkg::SEL_SBASE: static_base <= WDATA[15:0]; // [RULE12]
                cpu_regs_pkg::SEL_SP: begin
                    // Active pointer write follows the stack select [RULE10]
                    if (processor_flags_word[cpu_regs_pkg::FLG_STACK]) begin
                        user_stack_pointer <= WDATA[15:0];
                    end else begin
                        interrupt_stack_pointer <= WDATA[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Interrupt acceptance: running, enabled or non-maskable, and above current level [RULE18]
    assign accept = IRQ_REQ && (state == cpu_regs_pkg::ST_RUN)
        && (!IRQ_MASKABLE || processor_flags_word[cpu_regs_pkg::FLG_IEN])
        && (IRQ_LEVEL > processor_flags_word[14:12]); // [RULE17]
    assign IRQ_ACCEPT = accept;

    // Step request latched after each completed instruction while the step flag is set [RULE14]
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            step_pending <= 1'b0;
        end else if (soft_rst_q || accept) begin
            step_pending <= 1'b0;
        end else if (INSN_DONE
                && processor_flags_word[cpu_regs_pkg::FLG_STEP]) begin
            step_pending <= 1'b1;
        end
    end
    assign STEP_REQ = step_pending;

    // Flag word next value; hardware events win over software writes
    always_comb begin
        next_flags = processor_flags_word;
        if (WR && ADDR == cpu_regs_pkg::SEL_FLAGS) begin
            next_flags = WDATA[15:0] & cpu_regs_pkg::FLG_MASK; // [RULE19]
        end
        if (COND_WE) begin
            // Execution unit strobe loads all four condition flags at once [RULE24]
            next_flags[cpu_regs_pkg::FLG_CARRY] = COND_FLAGS[0]; // [RULE13]
            next_flags[cpu_regs_pkg::FLG_ZERO] = COND_FLAGS[1]; // [RULE15]
            next_flags[cpu_regs_pkg::FLG_SIGN] = COND_FLAGS[2];
            next_flags[cpu_regs_pkg::FLG_OVF] = COND_FLAGS[3];
        end
        if (SOFT_INT && SOFT_INT_NUM <= 6'(cpu_regs_pkg::SOFT_INT_MAX)) begin
            next_flags[cpu_regs_pkg::FLG_STACK] = 1'b0; // [RULE11]
        end
        if (accept) begin
            next_flags[cpu_regs_pkg::FLG_STACK] = 1'b0; // [RULE11]
            next_flags[cpu_regs_pkg::FLG_IEN] = 1'b0; // [RULE17]
            next_flags[cpu_regs_pkg::FLG_STEP] = 1'b0; // [RULE14]
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            processor_flags_word <= cpu_regs_pkg::RST_WORD; // [RULE23]
        end else if (soft_rst_q) begin
            processor_flags_word <= cpu_regs_pkg::RST_WORD; // [RULE22]
        end else begin
            processor_flags_word <= next_flags;
        end
    end

    // Boot sequencer: reset, fetch vector, run [RULE21]
    always_comb begin
        next_state = state;
        unique case (state)
            cpu_regs_pkg::ST_RESET: next_state = cpu_regs_pkg::ST_VECTOR;
            cpu_regs_pkg::ST_VECTOR: begin
                if (VECTOR_VALID) begin
                    next_state = cpu_regs_pkg::ST_RUN;
                end
            end
            cpu_regs_pkg::ST_RUN: next_state = cpu_regs_pkg::ST_RUN;
            default: next_state = cpu_regs_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state <= cpu_regs_pkg::ST_RESET;
        end else if (soft_rst_q) begin
            state <= cpu_regs_pkg::ST_RESET; // [RULE22]
        end else begin
            state <= next_state;
        end
    end

    // Program counter: loaded from vector, then by execution [RULE8]
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            instruction_pointer <= cpu_regs_pkg::RST_ADDR;
        end else if (soft_rst_q) begin
            instruction_pointer <= cpu_regs_pkg::RST_ADDR;
        end else if (state == cpu_regs_pkg::ST_VECTOR && VECTOR_VALID) begin
            instruction_pointer <= VECTOR_DATA; // [RULE21]
        end else if (state == cpu_regs_pkg::ST_RUN && PC_WE) begin
            instruction_pointer <= PC_NEXT;
        end else if (WR && ADDR == cpu_regs_pkg::SEL_IPTR) begin
            instruction_pointer <= WDATA;
        end
    end

    assign VECTOR_FETCH = (state == cpu_regs_pkg::ST_VECTOR);
    assign RUNNING = (state == cpu_regs_pkg::ST_RUN);
    assign INSTRUCTION_POINTER = instruction_pointer;
    assign FLAGS = processor_flags_word;

    // Composite views [RULE2] [RULE3] [RULE5]
    assign DATA_REG0_UPPER_BYTE = view[0][15:8];
    assign DATA_REG0_LOWER_BYTE = view[0][7:0];
    assign DATA_REG1_UPPER_BYTE = view[1][15:8];
    assign DATA_REG1_LOWER_BYTE = view[1][7:0];
    assign DATA_PAIR_LOW_32 = {view[2], view[0]};
    assign DATA_PAIR_HIGH_32 = {view[3], view[1]};
    assign ADDRESS_PAIR_32 = {view[5], view[4]};
    assign ACTIVE_SP = processor_flags_word[cpu_regs_pkg::FLG_STACK]
        ? user_stack_pointer : interrupt_stack_pointer; // [RULE10]

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            RDATA <= cpu_regs_pkg::RST_ADDR;
        end else if (RD) begin
            case (ADDR)
                cpu_regs_pkg::SEL_DATA0, cpu_regs_pkg::SEL_DATA1,
                cpu_regs_pkg::SEL_DATA2, cpu_regs_pkg::SEL_DATA3,
                cpu_regs_pkg::SEL_ADDR0, cpu_regs_pkg::SEL_ADDR1,
                cpu_regs_pkg::SEL_FRAME: RDATA <= {4'h0, view[ADDR[2:0]]};
                cpu_regs_pkg::SEL_IPTR: RDATA <= instruction_pointer;
                cpu_regs_pkg::SEL_VTAB: RDATA <= vector_table_base;
                cpu_regs_pkg::SEL_USP: RDATA <= {4'h0, user_stack_pointer};
                cpu_regs_pkg::SEL_ISP: begin
                    RDATA <= {4'h0, interrupt_stack_pointer};
                end
                cpu_regs_pkg::SEL_SBASE: RDATA <= {4'h0, static_base};
                cpu_regs_pkg::SEL_FLAGS: RDATA <= {4'h0, processor_flags_word};
                cpu_regs_pkg::SEL_SP: RDATA <= {4'h0, ACTIVE_SP};
                cpu_regs_pkg::SEL_STATUS: RDATA <= {17'h0, state, step_pending};
                default: RDATA <= 20'h00000;
            endcase
        end else begin
            RDATA <= 20'h00000;
        end
    end

    // Checks
    sequence s_accept;
        accept;
    endsequence
    AST_ACCEPT_CLEARS: assert property (@(posedge CLK_SYS) disable iff (RESET)
        s_accept ##1 !soft_rst_q |-> !FLAGS[6] && !FLAGS[7] && !FLAGS[1]) // [RULE17]
        else $error("accept did not clear flags");
    AST_LEVEL: assert property (@(posedge CLK_SYS) disable iff (RESET)
        IRQ_ACCEPT |-> IRQ_LEVEL > FLAGS[14:12]) // [RULE18]
        else $error("accepted at or below level");
    AST_RESERVED: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (FLAGS & ~cpu_regs_pkg::FLG_MASK) == 16'h0000) // [RULE19]
        else $error("reserved flag bit set");
    AST_VECTOR_LOAD: assert property (@(posedge CLK_SYS) disable iff (RESET)
        VECTOR_FETCH && VECTOR_VALID && !soft_rst_q
        |=> RUNNING && INSTRUCTION_POINTER == $past(VECTOR_DATA)) // [RULE21]
        else $error("vector not loaded");
    AST_SOFT_RESET: assert property (@(posedge CLK_SYS) disable iff (RESET)
        soft_rst_q |=> FLAGS == 16'h0000 && !RUNNING) // [RULE22]
        else $error("soft reset incomplete");
    AST_STEP: assert property (@(posedge CLK_SYS) disable iff (RESET)
        INSN_DONE && FLAGS[1] && !accept && !soft_rst_q |=> STEP_REQ) // [RULE14]
        else $error("step request missing");
    AST_SP_SEL: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ACTIVE_SP == (FLAGS[7] ? user_stack_pointer
        : interrupt_stack_pointer)) // [RULE10]
        else $error("wrong stack pointer");
    AST_COND: assert property (@(posedge CLK_SYS) disable iff (RESET)
        COND_WE && !soft_rst_q |=> FLAGS[0] == $past(COND_FLAGS[0])
        && FLAGS[2] == $past(COND_FLAGS[1])) // [RULE13]
        else $error("condition flags not taken");
endmodule
`default_nettype wire

// >>> hdl/cpu_regs_pkg.sv
// Constants for the CPU register set and flag word
// How it works
// RULE1: Four 16-bit general data registers
// RULE2: First two data registers split into bytes
// RULE3: Third over first, fourth over second
// RULE4: Two 16-bit address registers, also addressing bases
// RULE5: Address pair forms 32 bits, second high
// RULE6: Data, address, frame base banked twice
// RULE7: 16-bit frame base register
// RULE8: 20-bit program counter
// RULE9: 20-bit vector table base register
// RULE10: Bit 7 picks user or interrupt stack
// RULE11: Interrupt or low soft interrupt clears bit 7
// RULE12: 16-bit static base register
// RULE13: Bit 0 captures the carry
// RULE14: Bit 1 raises step interrupt, cleared on accept
// RULE15: Bits 2, 3, 5 hold zero, sign, overflow
// RULE16: Bit 4 selects register bank
// RULE17: Bit 6 gates interrupts, cleared on accept
// RULE18: Bits 12-14 priority; accept only above it
// RULE19: Bits 8-11 and 15 are reserved
// RULE20: Reset held low at least 20 cycles; RESET here is active high, and the bench holds it high for 20 cycles
// RULE21: After reset, fetch start from reset vector
// RULE22: Software reset equals hardware reset
// RULE23: Reset clears registers and flag word
// RULE24: Condition flags accepted from execution each instruction
package cpu_regs_pkg;
    // Register select codes on the plain register port
    localparam logic [3:0] SEL_DATA0 = 4'h0;
    localparam logic [3:0] SEL_DATA1 = 4'h1;
    localparam logic [3:0] SEL_DATA2 = 4'h2;
    localparam logic [3:0] SEL_DATA3 = 4'h3;
    localparam logic [3:0] SEL_ADDR0 = 4'h4;
    localparam logic [3:0] SEL_ADDR1 = 4'h5;
    localparam logic [3:0] SEL_FRAME = 4'h6;
    localparam logic [3:0] SEL_IPTR = 4'h7;
    localparam logic [3:0] SEL_VTAB = 4'h8;
    localparam logic [3:0] SEL_USP = 4'h9;
    localparam logic [3:0] SEL_ISP = 4'hA;
    localparam logic [3:0] SEL_SBASE = 4'hB;
    localparam logic [3:0] SEL_FLAGS = 4'hC;
    localparam logic [3:0] SEL_SP = 4'hD;
    localparam logic [3:0] SEL_STATUS = 4'hE;
    // Flag word bit positions
    localparam int FLG_CARRY = 0;
    localparam int FLG_STEP = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_SIGN = 3;
    localparam int FLG_BANK = 4;
    localparam int FLG_OVF = 5;
    localparam int FLG_IEN = 6;
    localparam int FLG_STACK = 7;
    localparam int FLG_LVL_LO = 12;
    // Writable bits of the flag word; reserved bits stay zero
    localparam logic [15:0] FLG_MASK = 16'h70FF;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [19:0] RST_ADDR = 20'h00000;
    // Reset vector entry address
    localparam logic [19:0] RESET_VECTOR = 20'hFFFFC;
    localparam int SOFT_INT_MAX = 31;
    // Fetch FSM
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_VECTOR = 2'b01,
        ST_RUN = 2'b10
    } boot_state_t;
endpackage

// >>> testbench/exec_model.sv
// Execution-side partner that answers reset vector fetches
`timescale 1ns/100ps
`default_nettype none
module exec_model #(
    parameter logic [19:0] VECTOR = 20'h0F1A4
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [3:0] DELAY_CYC,
    input wire logic VECTOR_FETCH,
    output logic VECTOR_VALID,
    output logic [19:0] VECTOR_DATA
);
    logic [3:0] cnt;
    logic give;
    // Answer once the programmed wait has run out
    assign give = VECTOR_FETCH && !VECTOR_VALID && cnt >= DELAY_CYC;
    // Data toggles off its valid cycle so a sample one cycle late never looks right
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cnt <= 4'h0;
            VECTOR_VALID <= 1'b0;
            VECTOR_DATA <= 20'hAAAAA;
        end else begin
            VECTOR_VALID <= give;
            VECTOR_DATA <= give ? VECTOR : ~VECTOR_DATA;
            cnt <= (VECTOR_FETCH && !give) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb_cpu_register_set.sv
// Self-checking bench for the CPU register set
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_register_set;
    localparam logic [19:0] VEC = 20'h0F1A4;
    logic CLK_SYS, RESET, SOFT_RESET, WR, RD, COND_WE, INSN_DONE;
    logic IRQ_REQ, IRQ_MASKABLE, SOFT_INT, PC_WE, VECTOR_VALID;
    logic STEP_REQ, IRQ_ACCEPT, VECTOR_FETCH, RUNNING;
    logic [3:0] ADDR, BYTE_SEL, COND_FLAGS, dly;
    logic [19:0] WDATA, RDATA, PC_NEXT, INSTRUCTION_POINTER, VECTOR_DATA;
    logic [7:0] b0h, b0l, b1h, b1l;
    logic [31:0] pl, ph, pa;
    logic [15:0] ACTIVE_SP, FLAGS;
    logic [2:0] IRQ_LEVEL;
    logic [5:0] SOFT_INT_NUM;
    logic rd_prev = 1'b0;
    logic ien, msk, acc;
    logic [19:0] v[12];
    logic [19:0] exp_q[$];
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    cpu_register_set u_cpu_register_set (.CLK_SYS(CLK_SYS), .RESET(RESET),
        .SOFT_RESET(SOFT_RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .BYTE_SEL(BYTE_SEL),
        .DATA_REG0_UPPER_BYTE(b0h), .DATA_REG0_LOWER_BYTE(b0l),
        .DATA_REG1_UPPER_BYTE(b1h), .DATA_REG1_LOWER_BYTE(b1l),
        .DATA_PAIR_LOW_32(pl), .DATA_PAIR_HIGH_32(ph),
        .ADDRESS_PAIR_32(pa), .ACTIVE_SP(ACTIVE_SP), .FLAGS(FLAGS),
        .COND_WE(COND_WE), .COND_FLAGS(COND_FLAGS), .INSN_DONE(INSN_DONE),
        .STEP_REQ(STEP_REQ), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
        .IRQ_MASKABLE(IRQ_MASKABLE), .IRQ_ACCEPT(IRQ_ACCEPT),
        .SOFT_INT(SOFT_INT), .SOFT_INT_NUM(SOFT_INT_NUM), .PC_WE(PC_WE),
        .PC_NEXT(PC_NEXT), .INSTRUCTION_POINTER(INSTRUCTION_POINTER),
        .VECTOR_FETCH(VECTOR_FETCH), .VECTOR_VALID(VECTOR_VALID),
        .VECTOR_DATA(VECTOR_DATA), .RUNNING(RUNNING));

    exec_model #(.VECTOR(VEC)) u_exec_model (.CLK_SYS(CLK_SYS),
        .RESET(RESET), .DELAY_CYC(dly), .VECTOR_FETCH(VECTOR_FETCH),
        .VECTOR_VALID(VECTOR_VALID), .VECTOR_DATA(VECTOR_DATA));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One bus cycle; every request signal moves once per edge
    task automatic bus(input logic w, input logic r, input logic [3:0] a,
                       input logic [19:0] d);
        @(posedge CLK_SYS);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
    endtask
    task automatic wr(input logic [3:0] a, input logic [19:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [19:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 20'h00000);
    endtask
    // Idle cycle, then let the edge's updates land before looking
    task automatic idle();
        bus(1'b0, 1'b0, ADDR, WDATA);
        #1;
    endtask
    // Wait for the vector fetch to finish, bounded
    task automatic boot();
        for (int i = 0; i < 50 && RUNNING !== 1'b1; i++) @(posedge CLK_SYS);
        #1;
        check(RUNNING, 1);
        check(INSTRUCTION_POINTER, VEC);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge CLK_SYS) rd_prev <= RD;
    always @(negedge CLK_SYS) begin
        if (rd_prev === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(RDATA, exp_q.pop_front());
        end
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    initial begin
        RESET = 1'b1;
        {SOFT_RESET, WR, RD, COND_WE, INSN_DONE, IRQ_REQ, SOFT_INT} = '0;
        {PC_WE, ADDR, WDATA, COND_FLAGS, IRQ_LEVEL, SOFT_INT_NUM} = '0;
        {PC_NEXT, dly} = '0;
        BYTE_SEL = 4'h3;
        IRQ_MASKABLE = 1'b1;
        void'($urandom(70));
        repeat (20) @(posedge CLK_SYS);
        RESET <= 1'b0;
        boot();
        // Reset values, unmapped select included
        for (int a = 0; a < 16; a++) begin
            if (a != 7 && a != 14) rd(4'(a), 20'h00000);
        end
        // Random words into registers 0 to 11 but the program counter, then read back
        for (int a = 0; a < 12; a++) begin
            v[a] = (a == 8) ? 20'($urandom) : {4'h0, 16'($urandom)};
            if (a != 7) wr(4'(a), v[a]);
        end
        for (int a = 0; a < 12; a++) begin
            if (a != 7) rd(4'(a), v[a]);
        end
        rd(4'hD, v[10]);
        idle();
        check(pl, {v[2][15:0], v[0][15:0]});
        check(ph, {v[3][15:0], v[1][15:0]});
        check(pa, {v[5][15:0], v[4][15:0]});
        check({b1h, b1l}, v[1][15:0]);
        check(ACTIVE_SP, v[10][15:0]);
        // Low byte lane alone must leave the upper byte untouched
        BYTE_SEL <= 4'h1;
        wr(4'h0, 20'h0A55A);
        idle();
        BYTE_SEL <= 4'h3;
        check({b0h, b0l}, {v[0][15:8], 8'h5A});
        // Bank 1 is a separate set of registers
        wr(4'hC, 20'h00010);
        idle();
        check(pl, 32'h00000000);
        wr(4'h0, 20'h0BEEF);
        wr(4'hC, 20'h00000);
        idle();
        check({b0h, b0l}, {v[0][15:8], 8'h5A});
        wr(4'hC, 20'h00010);
        idle();
        check({b0h, b0l}, 16'hBEEF);
        // Reserved bits never stick
        wr(4'hC, 20'hFFFFF);
        rd(4'hC, 20'h070FF);
        idle();
        check(ACTIVE_SP, v[9][15:0]);
        // Soft interrupt 32 keeps the stack select, 31 clears it
        for (int n = 32; n >= 31; n--) begin
            @(posedge CLK_SYS);
            SOFT_INT <= 1'b1;
            SOFT_INT_NUM <= 6'(n);
            @(posedge CLK_SYS);
            SOFT_INT <= 1'b0;
            #1;
            check(FLAGS[7], n > 31);
        end
        // Every condition flag pattern from the execution unit
        for (int c = 0; c < 16; c++) begin
            @(posedge CLK_SYS);
            COND_WE <= 1'b1;
            COND_FLAGS <= 4'(c);
            @(posedge CLK_SYS);
            COND_WE <= 1'b0;
            #1;
            check(FLAGS & 16'h002D, {c[3], 1'b0, c[2:1], 1'b0, c[0]});
        end
        // Every priority level against every request level
        for (int l = 0; l < 8; l++) begin
            for (int q = 0; q < 8; q++) begin
                ien = 1'($urandom);
                // Non-maskable requests ignore the enable flag
                msk = 1'($urandom);
                acc = (!msk || ien) && q > l;
                wr(4'hC, 20'(l << 12) | {12'h000, 1'b1, ien, 6'h00});
                idle();
                @(posedge CLK_SYS);
                IRQ_REQ <= 1'b1;
                IRQ_LEVEL <= 3'(q);
                IRQ_MASKABLE <= msk;
                @(negedge CLK_SYS);
                check(IRQ_ACCEPT, acc);
                @(posedge CLK_SYS);
                IRQ_REQ <= 1'b0;
                #1;
                check(FLAGS[7:6], acc ? 2'b00 : {1'b1, ien});
            end
        end
        // Single step request after an instruction completes
        wr(4'hC, 20'h00002);
        idle();
        @(posedge CLK_SYS);
        INSN_DONE <= 1'b1;
        @(posedge CLK_SYS);
        INSN_DONE <= 1'b0;
        #1;
        check(STEP_REQ, 1);
        // Status word: running state code and the pending step
        rd(4'hE, 20'h00005);
        idle();
        // Program counter load from the execution unit
        @(posedge CLK_SYS);
        PC_WE <= 1'b1;
        PC_NEXT <= 20'($urandom);
        @(posedge CLK_SYS);
        PC_WE <= 1'b0;
        #1;
        check(INSTRUCTION_POINTER, PC_NEXT);
        // Software reset behaves as the pin, with a slow vector answer
        dly <= 4'h4;
        @(posedge CLK_SYS);
        SOFT_RESET <= 1'b1;
        @(posedge CLK_SYS);
        SOFT_RESET <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        check(VECTOR_FETCH, 1);
        check(FLAGS, 16'h0000);
        boot();
        rd(4'h0, 20'h00000);
        rd(4'h9, 20'h00000);
        rd(4'h8, 20'h00000);
        idle();
        repeat (3) @(posedge CLK_SYS);
        check(exp_q.size(), 0);
        wrap_up();
    end
endmodule
`default_nettype wire
